//--- dv/sfa_checker.sv
`default_nettype none
module sfa_checker
	import sfa_pkg::*;
#(
	parameter int AR_VALID = 10
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_wr,
	input wire logic i_op_valid,
	input wire logic [3:0] i_op,
	input wire logic i_op_to_psw,
	input wire logic [3:0] i_op_a,
	input wire logic [3:0] i_op_b,
	input wire logic [3:0] o_result,
	input wire logic o_result_we,
	input wire logic o_bcd_flag,
	input wire logic o_compare_no_store_flag,
	input wire logic o_carry_flag,
	input wire logic o_zero_flag,
	input wire logic [AR_VALID-1:0] o_address_pointer_reg
);
	logic ar;
	logic [4:0] sum;
	assign ar = i_op_valid && i_op inside {OP_ADD, OP_ADDC, OP_SUB, OP_SUBC};
	assign sum = {1'b0, i_op_a} + {1'b0, i_op_b};
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);
	// Binary path only; decimal sums are judged by the bench model
	a_carry_add: assert property (ar && i_op == OP_ADD && !o_bcd_flag && !i_op_to_psw
		|=> o_carry_flag == $past(sum[4])) else $error("carry wrong");
	a_rotate_right_through_carry_move: assert property (i_op_valid && i_op == OP_ROTATE_RIGHT_THROUGH_CARRY
		|=> o_carry_flag == $past(i_op_a[0]) && o_result[3] == $past(o_carry_flag))
		else $error("rotate wrong");
	a_carry_hold: assert property (!i_wr && !(i_op_valid && (i_op_to_psw ||
		i_op inside {OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_ROTATE_RIGHT_THROUGH_CARRY})) |=> $stable(o_carry_flag))
		else $error("carry moved");
	a_psw_store: assert property (ar && i_op == OP_ADD && i_op_to_psw && !o_bcd_flag
		&& !o_compare_no_store_flag |=> o_carry_flag == $past(sum[2])
		&& o_zero_flag == $past(sum[1])) else $error("status store wrong");
	a_no_store: assert property (ar && o_compare_no_store_flag |=> !o_result_we)
		else $error("stored under compare");
	a_zero_keep: assert property (ar && o_compare_no_store_flag && !o_zero_flag
		|=> !o_zero_flag) else $error("zero set under compare");
	a_skip_cmp: assert property (i_op_valid && i_op inside {OP_SKT, OP_SKF}
		|=> !o_compare_no_store_flag) else $error("compare not cleared");
	a_ar_wrap: assert property (i_op_valid && i_op == OP_INC_AR && &o_address_pointer_reg
		|=> o_address_pointer_reg == '0) else $error("pointer no wrap");
endmodule // sfa_checker
bind status_flag_alu sfa_checker #(.AR_VALID(AR_VALID)) u_sfa_checker (.i_clk, .i_sys_rst,
	.i_wr, .i_op_valid, .i_op, .i_op_to_psw, .i_op_a, .i_op_b, .o_result, .o_result_we,
	.o_bcd_flag, .o_compare_no_store_flag, .o_carry_flag, .o_zero_flag, .o_address_pointer_reg);
`default_nettype wire

//--- dv/tb_status_flag_alu.sv
`default_nettype none
module tb_status_flag_alu
	import sfa_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0, i_op_valid = 0, i_op_to_psw = 0;
	logic [6:0] i_addr = 0;
	logic [3:0] i_wdata = 0, i_op = 0, i_op_a = 0, i_op_b = 0, o_rdata, o_result;
	logic o_result_we, o_skip, o_bcd_flag, o_compare_no_store_flag, o_carry_flag;
	logic o_zero_flag, o_index_modify_enable;
	logic [9:0] o_address_pointer_reg;
	logic [10:0] o_index_pointer_reg;
	logic [31:0] lfsr = 32'hB4EF;
	logic [31:0] v;
	logic [3:0] ro, ra, rb;
	logic [6:0] ptr_addrs [6] = '{ADDR_AR2, ADDR_AR1, ADDR_AR0, ADDR_IXH, ADDR_IXM, ADDR_IXL};
	int err_total = 0, n_compared = 0;
	bit cy, z, cmp, bcd, index_modify_enable;
	always #50 i_clk = ~i_clk;
	status_flag_alu DUT (.i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_op_valid, .i_op, .i_op_to_psw, .i_op_a, .i_op_b, .o_result, .o_result_we, .o_skip,
		.o_bcd_flag, .o_compare_no_store_flag, .o_carry_flag, .o_zero_flag,
		.o_index_modify_enable, .o_address_pointer_reg, .o_index_pointer_reg);
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("compared %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Every access leaves an idle edge so no strobe is assigned twice in a step
	task automatic wr(logic [6:0] a, logic [3:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(logic [6:0] a, logic [3:0] exp);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 chk("rdata", o_rdata, exp);
	endtask
	task automatic setf(logic [3:0] f, logic d);
		wr(ADDR_PSW, f);
		wr(ADDR_RPL, {3'h0, d});
		{cmp, cy, z, index_modify_enable} = f;
		bcd = d;
	endtask
	task automatic op(logic [3:0] o, logic [3:0] a, logic [3:0] b, logic p);
		int r, we, sk;
		bit c;
		r = 0;
		we = 0;
		sk = 0;
		c = 0;
		if (o inside {OP_ADD, OP_ADDC}) begin
			r = a + b + (o == OP_ADDC ? cy : 0);
			c = r > 15;
			if (bcd && r > 9) begin
				r += 6;
				c = 1;
			end
		end else if (o inside {OP_SUB, OP_SUBC}) begin
			r = a - b - (o == OP_SUBC ? cy : 0);
			c = r < 0;
			if (bcd && c)
				r -= 6;
		end
		r = r & 15;
		if (o inside {[OP_ADD:OP_SUBC]}) begin
			cy = c;
			if (r != 0)
				z = 0;
			else if (!cmp)
				z = 1;
			we = !cmp && !p;
			if (p && !cmp)
				{cmp, cy, z, index_modify_enable} = r[3:0];
		end else if (o inside {[OP_AND:OP_XOR]}) begin
			r = o == OP_AND ? a & b : o == OP_OR ? a | b : a ^ b;
			we = !p;
			if (p)
				{cmp, cy, z, index_modify_enable} = r[3:0];
		end else if (o == OP_ROTATE_RIGHT_THROUGH_CARRY) begin
			r = {cy, a[3:1]};
			cy = a[0];
			we = 1;
		end else if (o inside {OP_SKT, OP_SKF}) begin
			sk = o == OP_SKT ? (a & b) == b : (a & b) == 0;
			cmp = 0;
		end
		@(posedge i_clk);
		{i_op_valid, i_op, i_op_a, i_op_b, i_op_to_psw} <= {1'b1, o, a, b, p};
		@(posedge i_clk);
		i_op_valid <= 1'b0;
		#1;
		if (!p)
			chk("we", o_result_we, we);
		if (we)
			chk("result", o_result, r);
		chk("skip", o_skip, sk);
		chk("carry", o_carry_flag, cy);
		chk("zero", o_zero_flag, z);
		chk("cmp", o_compare_no_store_flag, cmp);
		chk("bcd_ixe", {o_bcd_flag, o_index_modify_enable}, {bcd, index_modify_enable});
	endtask
	initial begin
		repeat (10000) @(posedge i_clk);
		err_total++;
		give_verdict();
	end
	initial begin
		repeat (4) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		#1 chk("flags", {o_bcd_flag, o_compare_no_store_flag, o_carry_flag, o_zero_flag,
			o_index_modify_enable, o_address_pointer_reg}, 0);
		rd(ADDR_PSW, 4'h0);
		wr(ADDR_AR3, 4'hF);
		rd(ADDR_AR3, 4'h0);
		foreach (ptr_addrs[i])
			wr(ptr_addrs[i], 4'hF);
		rd(ADDR_AR2, 4'h3);
		rd(ADDR_IXH, 4'h7);
		op(OP_INC_AR, 0, 0, 0);
		op(OP_INC_IX, 0, 0, 0);
		chk("ptrs", {o_address_pointer_reg, o_index_pointer_reg}, 0);
		setf(4'h1, 0);
		op(OP_ADD, 4'h1, 4'hF, 1);
		setf(4'h8, 0);
		op(OP_SKT, 4'h5, 4'h4, 0);
		repeat (300) begin
			v = rnd();
			setf(v[3:0], v[4]);
			// Operands stay in bench variables; only the op task drives the pins
			ro = 4'(v[15:8] % 10 + 1);
			{ra, rb} = v[23:16];
			if (bcd && ro < 5)
				{ra, rb} = {4'(ra % 10), 4'(rb % 10)};
			if (ro < 8 && v[7:5] == 0)
				op(ro, v[3:0], rb, 1);
			else
				op(ro, ra, rb, 0);
		end
		give_verdict();
	end
endmodule // tb_status_flag_alu
`default_nettype wire

//--- src/nibble_adder.sv
`default_nettype none
module nibble_adder
	import sfa_pkg::*;
(
	input wire logic [3:0] i_a,
	input wire logic [3:0] i_b,
	input wire logic i_cin,
	input wire logic i_sub,
	input wire logic i_bcd,
	output logic [3:0] o_res,
	output logic o_cout
);
	logic [4:0] raw;
	logic [4:0] adj;

	always_comb begin
		if (!i_sub) begin
			raw = {1'b0, i_a} + {1'b0, i_b} + {4'h0, i_cin};
			adj = raw;
			if (i_bcd) begin
				// Decimal carry comes from the digit overflowing nine
				o_cout = (raw > BCD_MAX);
				if (o_cout) begin
					adj = raw + BCD_ADJ;
				end
			end else begin
				o_cout = raw[4];
			end
		end else begin
			raw = {1'b0, i_a} - {1'b0, i_b} - {4'h0, i_cin};
			adj = raw;
			o_cout = raw[4];
			if (i_bcd && o_cout) begin
				adj = raw - BCD_ADJ;
			end
		end
		o_res = adj[3:0];
	end
endmodule // nibble_adder
`default_nettype wire

//--- src/ptr_inc.sv
`default_nettype none
module ptr_inc #(
	parameter int W = 10
) (
	input wire logic [W-1:0] i_val,
	output logic [W-1:0] o_val
);
	// Only valid bits are kept, so all ones rolls over to all zeros
	assign o_val = i_val + W'(1);
endmodule // ptr_inc
`default_nettype wire

//--- src/sfa_pkg.sv
`default_nettype none
package sfa_pkg;
	localparam int NIB_W = 4;
	localparam int BUS_ADDR_W = 7;
	localparam int PTR_FULL_W = 16;
	localparam int IX_FULL_W = 12;

	// Register offsets, one nibble each
	localparam logic [6:0] ADDR_AR3 = 7'h74;
	localparam logic [6:0] ADDR_AR2 = 7'h75;
	localparam logic [6:0] ADDR_AR1 = 7'h76;
	localparam logic [6:0] ADDR_AR0 = 7'h77;
	localparam logic [6:0] ADDR_IXH = 7'h7A;
	localparam logic [6:0] ADDR_IXM = 7'h7B;
	localparam logic [6:0] ADDR_IXL = 7'h7C;
	localparam logic [6:0] ADDR_RPL = 7'h7E;
	localparam logic [6:0] ADDR_PSW = 7'h7F;

	// Status nibble bit positions
	localparam int PSW_IXE_BIT = 0;
	localparam int PSW_Z_BIT = 1;
	localparam int PSW_CY_BIT = 2;
	localparam int PSW_CMP_BIT = 3;
	// Decimal-mode flag sits in bit 0 of the lower pointer nibble
	localparam int RPL_BCD_BIT = 0;

	localparam logic [3:0] NIB_ZERO = 4'h0;
	localparam logic [4:0] BCD_MAX = 5'h09;
	localparam logic [4:0] BCD_ADJ = 5'h06;
	localparam logic [2:0] RPL_HI_RESET = 3'h0;

	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_ADD = 4'h1,
		OP_ADDC = 4'h2,
		OP_SUB = 4'h3,
		OP_SUBC = 4'h4,
		OP_AND = 4'h5,
		OP_OR = 4'h6,
		OP_XOR = 4'h7,
		OP_ROTATE_RIGHT_THROUGH_CARRY = 4'h8,
		OP_SKT = 4'h9,
		OP_SKF = 4'hA,
		OP_INC_AR = 4'hB,
		OP_INC_IX = 4'hC
	} op_t;
endpackage
`default_nettype wire

//--- src/status_flag_alu.sv
`default_nettype none
// Functional notes
// - Add or subtract sets carry on carry or borrow, clears it otherwise.
// - Rotate right through carry: old carry to MSB, LSB to carry.
// - Carry changes only by arithmetic, rotate, status-nibble stores and PSW writes; arithmetic carry is the same whatever compare flag.
// - Decimal flag one gives BCD arithmetic, zero gives 4-bit binary.
// - Logic, bit tests and rotates ignore the decimal flag; compares use it like arithmetic.
// - Arithmetic into the status nibble stores result there, overriding carry.
// - Hard-wired zero bits ignore writes and read zero.
// - Incrementing an all-ones pointer wraps it to zero.
// - A bit-test instruction clears the compare flag.
// - Compare flag set: arithmetic result not stored, only carry and zero.
// - Nonzero result clears zero; zero result sets it only if compare clear.
// - Reset clears decimal, compare, carry, zero and index enable flags.
module status_flag_alu
	import sfa_pkg::*;
#(
	parameter int AR_VALID = 10,
	parameter int IX_VALID = 11
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [6:0] i_addr,
	input wire logic [3:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [3:0] o_rdata,
	input wire logic i_op_valid,
	input wire logic [3:0] i_op,
	input wire logic i_op_to_psw,
	input wire logic [3:0] i_op_a,
	input wire logic [3:0] i_op_b,
	output logic [3:0] o_result,
	output logic o_result_we,
	output logic o_skip,
	output logic o_bcd_flag,
	output logic o_compare_no_store_flag,
	output logic o_carry_flag,
	output logic o_zero_flag,
	output logic o_index_modify_enable,
	output logic [AR_VALID-1:0] o_address_pointer_reg,
	output logic [IX_VALID-1:0] o_index_pointer_reg
);
	if (AR_VALID < 1 || AR_VALID > PTR_FULL_W) begin : g_bad_ar
		$error("AR_VALID out of range");
	end
	if (IX_VALID < 1 || IX_VALID > IX_FULL_W) begin : g_bad_ix
		$error("IX_VALID out of range");
	end

	function automatic logic [15:0] put_nib(input logic [15:0] v, input int idx,
		input logic [3:0] d);
		logic [15:0] r;
		r = v;
		r[idx*NIB_W +: NIB_W] = d;
		return r;
	endfunction

	function automatic logic [3:0] get_nib(input logic [15:0] v, input int idx);
		return v[idx*NIB_W +: NIB_W];
	endfunction

	op_t op;
	logic [3:0] sum;
	logic sum_cout;
	logic is_sub;
	logic use_cin;
	logic [AR_VALID-1:0] ar_inc;
	logic [IX_VALID-1:0] ix_inc;
	logic [15:0] ar_ext;
	logic [15:0] ix_ext;

	logic bcd, cmp, cy, zf, index_modify_enable;
	logic [2:0] rpl_hi;
	logic [AR_VALID-1:0] ar;
	logic [IX_VALID-1:0] ix;
	logic [3:0] rdata, result;
	logic result_we, skip;
	logic next_bcd, next_cmp, next_cy, next_zf, next_ixe;
	logic [2:0] next_rpl_hi;
	logic [AR_VALID-1:0] next_ar;
	logic [IX_VALID-1:0] next_ix;
	logic [3:0] next_rdata, next_result;
	logic next_result_we, next_skip;

	assign op = op_t'(i_op);
	assign is_sub = (op == OP_SUB) || (op == OP_SUBC);
	assign use_cin = (op == OP_ADDC) || (op == OP_SUBC);
	// Bits above the valid width are held at zero and never stored
	assign ar_ext = 16'(ar);
	assign ix_ext = 16'(ix);

	nibble_adder u_add (
		.i_a(i_op_a),
		.i_b(i_op_b),
		.i_cin(use_cin & cy),
		.i_sub(is_sub),
		.i_bcd(bcd),
		.o_res(sum),
		.o_cout(sum_cout)
	);

	ptr_inc #(.W(AR_VALID)) u_ar_inc (
		.i_val(ar),
		.o_val(ar_inc)
	);

	ptr_inc #(.W(IX_VALID)) u_ix_inc (
		.i_val(ix),
		.o_val(ix_inc)
	);

	always_comb begin
		next_bcd = bcd;
		next_cmp = cmp;
		next_cy = cy;
		next_zf = zf;
		next_ixe = index_modify_enable;
		next_rpl_hi = rpl_hi;
		next_ar = ar;
		next_ix = ix;
		next_rdata = NIB_ZERO;
		next_result = result;
		next_result_we = 1'b0;
		next_skip = 1'b0;

		// Read data stand for one cycle only; unmapped addresses read zero
		if (i_rd) begin
			unique case (i_addr)
				ADDR_AR3: next_rdata = get_nib(ar_ext, 3);
				ADDR_AR2: next_rdata = get_nib(ar_ext, 2);
				ADDR_AR1: next_rdata = get_nib(ar_ext, 1);
				ADDR_AR0: next_rdata = get_nib(ar_ext, 0);
				ADDR_IXH: next_rdata = get_nib(ix_ext, 2);
				ADDR_IXM: next_rdata = get_nib(ix_ext, 1);
				ADDR_IXL: next_rdata = get_nib(ix_ext, 0);
				ADDR_RPL: next_rdata = {rpl_hi, bcd};
				ADDR_PSW: next_rdata = {cmp, cy, zf, index_modify_enable};
				default: next_rdata = NIB_ZERO;
			endcase
		end

		// Software writes first; a same-cycle instruction overrides the flags
		if (i_wr) begin
			unique case (i_addr)
				ADDR_AR3: next_ar = AR_VALID'(put_nib(ar_ext, 3, i_wdata));
				ADDR_AR2: next_ar = AR_VALID'(put_nib(ar_ext, 2, i_wdata));
				ADDR_AR1: next_ar = AR_VALID'(put_nib(ar_ext, 1, i_wdata));
				ADDR_AR0: next_ar = AR_VALID'(put_nib(ar_ext, 0, i_wdata));
				ADDR_IXH: next_ix = IX_VALID'(put_nib(ix_ext, 2, i_wdata));
				ADDR_IXM: next_ix = IX_VALID'(put_nib(ix_ext, 1, i_wdata));
				ADDR_IXL: next_ix = IX_VALID'(put_nib(ix_ext, 0, i_wdata));
				ADDR_RPL: begin
					next_rpl_hi = i_wdata[3:1];
					next_bcd = i_wdata[RPL_BCD_BIT];
				end
				ADDR_PSW: begin
					next_cmp = i_wdata[PSW_CMP_BIT];
					next_cy = i_wdata[PSW_CY_BIT];
					next_zf = i_wdata[PSW_Z_BIT];
					next_ixe = i_wdata[PSW_IXE_BIT];
				end
				default: ;
			endcase
		end

		if (i_op_valid) begin
			unique case (op)
				OP_ADD, OP_ADDC, OP_SUB, OP_SUBC: begin
					next_cy = sum_cout;
					if (sum != NIB_ZERO) begin
						next_zf = 1'b0;
					end else if (!cmp) begin
						next_zf = 1'b1;
					end
					if (!cmp) begin
						if (i_op_to_psw) begin
							// Stored result replaces the fresh carry and zero
							next_cmp = sum[PSW_CMP_BIT];
							next_cy = sum[PSW_CY_BIT];
							next_zf = sum[PSW_Z_BIT];
							next_ixe = sum[PSW_IXE_BIT];
						end else begin
							next_result = sum;
							next_result_we = 1'b1;
						end
					end
				end
				OP_AND, OP_OR, OP_XOR: begin
					// Logic ignores the decimal flag and touches flags only when stored to the status nibble
					unique case (op)
						OP_AND: next_result = i_op_a & i_op_b;
						OP_OR: next_result = i_op_a | i_op_b;
						default: next_result = i_op_a ^ i_op_b;
					endcase
					if (i_op_to_psw) begin
						next_cmp = next_result[PSW_CMP_BIT];
						next_cy = next_result[PSW_CY_BIT];
						next_zf = next_result[PSW_Z_BIT];
						next_ixe = next_result[PSW_IXE_BIT];
					end else begin
						next_result_we = 1'b1;
					end
				end
				OP_ROTATE_RIGHT_THROUGH_CARRY: begin
					next_result = {cy, i_op_a[3:1]};
					next_cy = i_op_a[0];
					next_result_we = 1'b1;
				end
				OP_SKT: begin
					next_skip = ((i_op_a & i_op_b) == i_op_b);
					next_cmp = 1'b0;
				end
				OP_SKF: begin
					next_skip = ((i_op_a & i_op_b) == NIB_ZERO);
					next_cmp = 1'b0;
				end
				OP_INC_AR: next_ar = ar_inc;
				OP_INC_IX: next_ix = ix_inc;
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			bcd <= 1'b0;
			cmp <= 1'b0;
			cy <= 1'b0;
			zf <= 1'b0;
			index_modify_enable <= 1'b0;
			rpl_hi <= RPL_HI_RESET;
			ar <= '0;
			ix <= '0;
			rdata <= NIB_ZERO;
			result <= NIB_ZERO;
			result_we <= 1'b0;
			skip <= 1'b0;
		end else begin
			bcd <= next_bcd;
			cmp <= next_cmp;
			cy <= next_cy;
			zf <= next_zf;
			index_modify_enable <= next_ixe;
			rpl_hi <= next_rpl_hi;
			ar <= next_ar;
			ix <= next_ix;
			rdata <= next_rdata;
			result <= next_result;
			result_we <= next_result_we;
			skip <= next_skip;
		end
	end

	assign o_rdata = rdata;
	assign o_result = result;
	assign o_result_we = result_we;
	assign o_skip = skip;
	assign o_bcd_flag = bcd;
	assign o_compare_no_store_flag = cmp;
	assign o_carry_flag = cy;
	assign o_zero_flag = zf;
	assign o_index_modify_enable = index_modify_enable;
	assign o_address_pointer_reg = ar;
	assign o_index_pointer_reg = ix;
endmodule // status_flag_alu
`default_nettype wire
